// *** rtl/wdr_pkg.sv ***
package wdr_pkg;

   // Register indexes; the byte address on the bus is four times the index.
   localparam logic [5:0] IDX_PWR_EN       = 6'h01;
   localparam logic [5:0] IDX_PWR_STS2     = 6'h03;
   localparam logic [5:0] IDX_PWR_EN2      = 6'h06;
   localparam logic [5:0] IDX_UNIT_SEL     = 6'h11;
   localparam logic [5:0] IDX_WD_CFG       = 6'h13;
   localparam logic [5:0] IDX_MGMT_STS3    = 6'h18;
   localparam logic [5:0] IDX_MGMT_EN3     = 6'h19;
   localparam logic [5:0] IDX_TIMEOUT_VAL  = 6'h20;
   localparam logic [5:0] IDX_WD_CTRL      = 6'h21;
   localparam logic [5:0] IDX_GPIO_POL2    = 6'h22;
   localparam logic [5:0] IDX_ALT_FUNC1    = 6'h23;
   localparam logic [5:0] IDX_ALT_FUNC3    = 6'h24;
   localparam logic [5:0] IDX_IRQ_STS      = 6'h28;
   localparam logic [5:0] IDX_IRQ_CLR      = 6'h29;
   localparam logic [5:0] IDX_IRQ_EN       = 6'h2a;

   // Field positions.
   localparam int BIT_PWR_GLOBAL_EN = 0;
   localparam int BIT_PWR_WD        = 7;
   localparam int BIT_UNIT_MINUTES  = 7;
   localparam int BIT_MAP_LO        = 4;
   localparam int BIT_MGMT_WD       = 0;
   localparam int BIT_CTRL_STATUS   = 0;
   localparam int BIT_CTRL_FORCE    = 2;
   localparam int BIT_POL_WD        = 1;
   localparam int BIT_ALT1_LO       = 4;
   localparam int BIT_ALT3_LO       = 2;
   localparam logic [1:0] ALT1_MGMT_SEL = 2'h1;
   localparam logic [1:0] ALT3_WD_SEL   = 2'h2;

   // Interrupt status bits.
   localparam int IRQ_W          = 3;
   localparam int IRQ_BIT_EVENT  = 0;
   localparam int IRQ_BIT_RELOAD = 1;
   localparam int IRQ_BIT_FORCE  = 2;

   // Reset values.
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic [7:0] RST_TO_VAL = 8'h00;

   // Timing: a unit tick is one second, or one minute of sixty seconds when minutes are selected.
   localparam int CLK_KHZ          = 40000;
   localparam int SECOND_MS        = 1000;
   localparam int SECOND_CYCLES    = SECOND_MS * CLK_KHZ;
   localparam int SECONDS_PER_MIN  = 60;

endpackage

// *** rtl/wdr_top.sv ***
`timescale 1ns/1ps
module wdr_top
   import wdr_pkg::*;
#(
   parameter int SEC_CYCLES = wdr_pkg::SECOND_CYCLES
) (
   // Clock and reset.
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Event outputs.
   output logic             power_event_out_n,
   output logic             mgmt_irq_out_n,
   output logic             shared_pin_twentyone_o,
   output logic             shared_pin_twentyone_oe,
   output logic             serirq_request,
   output logic [3:0]       serirq_slot,
   output logic             irq
);
   import wdr_pkg::*;

   // The prescaler needs at least two cycles per second to form a tick.
   if (SEC_CYCLES < 2) begin : g_sec_check
      $error("SEC_CYCLES must be at least 2.");
   end

   localparam int SW = $clog2(SEC_CYCLES);

   // Bus state.
   logic        wr_q, rd_q;
   logic [5:0]  addr_q;
   logic [7:0]  wd;
   logic        wr_ok;

   // Registers.
   logic [7:0]  pwr_en_q, pwr_en2_q, unit_q, cfg_q, mgmt_en3_q;
   logic [7:0]  to_val_q, pol2_q, alt1_q, alt3_q;
   logic        pwr_sts_q, mgmt_sts_q, status_q, status_prev_q;
   logic [IRQ_W-1:0] irq_sts_q, irq_en_q, irq_set;

   // Counting.
   logic [SW-1:0] sec_cnt_q;
   logic [5:0]    min_cnt_q;
   logic          sec_tick, min_tick, unit_tick;
   logic [7:0]    count_q;
   logic          load, force_wr, expire, wd_event, wd_level;

   assign wd       = hwdata[7:0];
   assign wr_ok    = wr_q;
   assign load     = wr_ok && addr_q == IDX_TIMEOUT_VAL;
   assign force_wr = wr_ok && addr_q == IDX_WD_CTRL && wd[BIT_CTRL_FORCE];

   // Address phase capture; reads take one wait state so the data comes from a flop.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
         addr_q <= 6'h00;
      end else begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         if (hsel && htrans[1] && hready) begin
            wr_q   <= hwrite;
            rd_q   <= !hwrite;
            addr_q <= haddr[7:2];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hreadyout <= 1'b1;
         hrdata    <= 32'h0000_0000;
      end else begin
         hreadyout <= 1'b1;
         if (hsel && htrans[1] && hready && !hwrite) begin
            hreadyout <= 1'b0;
         end
         if (rd_q) begin
            hrdata <= 32'h0000_0000;
            case (addr_q)
               IDX_PWR_EN:      hrdata[7:0] <= pwr_en_q;
               IDX_PWR_STS2:    hrdata[BIT_PWR_WD] <= pwr_sts_q;
               IDX_PWR_EN2:     hrdata[7:0] <= pwr_en2_q;
               IDX_UNIT_SEL:    hrdata[7:0] <= unit_q;
               IDX_WD_CFG:      hrdata[7:0] <= cfg_q;
               IDX_MGMT_STS3:   hrdata[BIT_MGMT_WD] <= mgmt_sts_q;
               IDX_MGMT_EN3:    hrdata[7:0] <= mgmt_en3_q;
               IDX_TIMEOUT_VAL: hrdata[7:0] <= to_val_q;
               IDX_WD_CTRL:     hrdata[BIT_CTRL_STATUS] <= status_q;
               IDX_GPIO_POL2:   hrdata[7:0] <= pol2_q;
               IDX_ALT_FUNC1:   hrdata[7:0] <= alt1_q;
               IDX_ALT_FUNC3:   hrdata[7:0] <= alt3_q;
               IDX_IRQ_STS:     hrdata[IRQ_W-1:0] <= irq_sts_q;
               IDX_IRQ_EN:      hrdata[IRQ_W-1:0] <= irq_en_q;
               default:         hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   // Plain read/write configuration registers.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pwr_en_q   <= RST_BYTE;
         pwr_en2_q  <= RST_BYTE;
         unit_q     <= RST_BYTE;
         cfg_q      <= RST_BYTE;
         mgmt_en3_q <= RST_BYTE;
         to_val_q   <= RST_TO_VAL;
         pol2_q     <= RST_BYTE;
         alt1_q     <= RST_BYTE;
         alt3_q     <= RST_BYTE;
         irq_en_q   <= '0;
      end else if (wr_ok) begin
         case (addr_q)
            IDX_PWR_EN:      pwr_en_q   <= wd;
            IDX_PWR_EN2:     pwr_en2_q  <= wd;
            IDX_UNIT_SEL:    unit_q     <= wd;
            IDX_WD_CFG:      cfg_q      <= wd;
            IDX_MGMT_EN3:    mgmt_en3_q <= wd;
            IDX_TIMEOUT_VAL: to_val_q   <= wd;
            IDX_GPIO_POL2:   pol2_q     <= wd;
            IDX_ALT_FUNC1:   alt1_q     <= wd;
            IDX_ALT_FUNC3:   alt3_q     <= wd;
            IDX_IRQ_EN:      irq_en_q   <= wd[IRQ_W-1:0];
            default:         ;
         endcase
      end
   end

   // Seconds prescaler and minute divider.
   assign sec_tick  = sec_cnt_q == SW'(SEC_CYCLES - 1);
   assign min_tick  = sec_tick && min_cnt_q == 6'(SECONDS_PER_MIN - 1);
   assign unit_tick = unit_q[BIT_UNIT_MINUTES] ? min_tick : sec_tick;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sec_cnt_q <= '0;
         min_cnt_q <= 6'h00;
      end else if (sec_tick) begin
         sec_cnt_q <= '0;
         min_cnt_q <= min_tick ? 6'h00 : min_cnt_q + 6'h01;
      end else begin
         sec_cnt_q <= sec_cnt_q + SW'(1);
      end
   end

   // Down-counter; a zero count stands still, which covers the disabled case.
   assign expire = !load && !force_wr && count_q == 8'h01 && unit_tick;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         count_q <= RST_TO_VAL;
      end else if (force_wr) begin
         count_q <= 8'h00;
      end else if (load) begin
         count_q <= wd;
      end else if (count_q != 8'h00 && unit_tick) begin
         count_q <= count_q - 8'h01;
      end
   end

   // Timeout status: hardware set wins over a host clear in the same cycle.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         status_q      <= 1'b0;
         status_prev_q <= 1'b0;
      end else begin
         status_prev_q <= status_q;
         if (expire || force_wr) begin
            status_q <= 1'b1;
         end else if (wr_ok && addr_q == IDX_WD_CTRL) begin
            status_q <= wd[BIT_CTRL_STATUS];
         end
      end
   end

   assign wd_event = status_q && !status_prev_q;
   assign wd_level = status_q ^ pol2_q[BIT_POL_WD];

   // Sticky event status bits, cleared by writing one.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pwr_sts_q  <= 1'b0;
         mgmt_sts_q <= 1'b0;
      end else begin
         if (wd_event) begin
            pwr_sts_q <= 1'b1;
         end else if (wr_ok && addr_q == IDX_PWR_STS2 && wd[BIT_PWR_WD]) begin
            pwr_sts_q <= 1'b0;
         end
         if (wd_event) begin
            mgmt_sts_q <= 1'b1;
         end else if (wr_ok && addr_q == IDX_MGMT_STS3 && wd[BIT_MGMT_WD]) begin
            mgmt_sts_q <= 1'b0;
         end
      end
   end

   // Event outputs.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         power_event_out_n       <= 1'b1;
         mgmt_irq_out_n          <= 1'b1;
         shared_pin_twentyone_o  <= 1'b0;
         shared_pin_twentyone_oe <= 1'b0;
         serirq_request          <= 1'b0;
         serirq_slot             <= 4'h0;
      end else begin
         power_event_out_n <= !(pwr_sts_q && pwr_en_q[BIT_PWR_GLOBAL_EN]
                                && pwr_en2_q[BIT_PWR_WD]);
         mgmt_irq_out_n <= !(mgmt_sts_q && mgmt_en3_q[BIT_MGMT_WD]
                             && alt1_q[BIT_ALT1_LO+:2] == ALT1_MGMT_SEL);
         if (alt3_q[BIT_ALT3_LO+:2] == ALT3_WD_SEL) begin
            shared_pin_twentyone_o  <= wd_level;
            shared_pin_twentyone_oe <= 1'b1;
         end else begin
            shared_pin_twentyone_o  <= 1'b0;
            shared_pin_twentyone_oe <= 1'b0;
         end
         serirq_request <= status_q && cfg_q[BIT_MAP_LO+:4] != 4'h0;
         serirq_slot    <= cfg_q[BIT_MAP_LO+:4];
      end
   end

   // Block interrupt: sticky status, write-one clear, enable mask.
   always_comb begin
      irq_set = '0;
      irq_set[IRQ_BIT_EVENT]  = wd_event;
      irq_set[IRQ_BIT_RELOAD] = load && wd != 8'h00;
      irq_set[IRQ_BIT_FORCE]  = force_wr;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_sts_q <= '0;
         irq <= 1'b0;
      end else begin
         if (wr_ok && addr_q == IDX_IRQ_CLR) begin
            irq_sts_q <= (irq_sts_q & ~wd[IRQ_W-1:0]) | irq_set;
         end else begin
            irq_sts_q <= irq_sts_q | irq_set;
         end
         irq <= |(irq_sts_q & irq_en_q);
      end
   end

   // Checks.
   sequence force_write_s;
      force_wr;
   endsequence

   sequence forced_result_s;
      count_q == 8'h00 && status_q && wd_event ##1 status_prev_q && !wd_event;
   endsequence

   sequence read_wait_s;
      !hreadyout ##1 hreadyout;
   endsequence

   disabled_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      count_q == 8'h00 && !load |=> count_q == 8'h00)
      else $error("Counter moved while disabled.");

   reload_count_a: assert property (@(posedge clk_sys) disable iff (rst)
      load && !force_wr |=> count_q == $past(wd))
      else $error("Counter did not reload.");

   expire_status_a: assert property (@(posedge clk_sys) disable iff (rst)
      expire |=> status_q && count_q == 8'h00 ##1 !status_prev_q == 1'b0)
      else $error("Expiry did not set status.");

   event_edge_a: assert property (@(posedge clk_sys) disable iff (rst)
      wd_event |-> $rose(status_q))
      else $error("Event without a rising status edge.");

   pwr_out_a: assert property (@(posedge clk_sys) disable iff (rst)
      wd_event && pwr_en_q[BIT_PWR_GLOBAL_EN] && pwr_en2_q[BIT_PWR_WD]
      && !wr_ok |=> ##1 !power_event_out_n)
      else $error("Power event output not asserted.");

   mgmt_out_a: assert property (@(posedge clk_sys) disable iff (rst)
      !mgmt_irq_out_n |-> $past(mgmt_sts_q) && $past(mgmt_en3_q[BIT_MGMT_WD]))
      else $error("Management output without cause.");

   pin_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
      alt3_q[BIT_ALT3_LO+:2] == ALT3_WD_SEL && $stable(alt3_q) |=>
      shared_pin_twentyone_oe && shared_pin_twentyone_o == $past(wd_level))
      else $error("Shared pin does not follow watchdog.");

   serirq_a: assert property (@(posedge clk_sys) disable iff (rst)
      serirq_request |-> $past(cfg_q[BIT_MAP_LO+:4]) != 4'h0 && serirq_slot != 4'h0)
      else $error("Serial request with zero mapping.");

   force_a: assert property (@(posedge clk_sys) disable iff (rst)
      force_write_s ##0 !status_q |=> forced_result_s)
      else $error("Force did not time out.");

   tick_only_a: assert property (@(posedge clk_sys) disable iff (rst)
      !unit_tick && !load && !force_wr |=> $stable(count_q))
      else $error("Counter moved without a tick.");

   status_write_a: assert property (@(posedge clk_sys) disable iff (rst)
      wr_ok && addr_q == IDX_WD_CTRL && !expire && !force_wr
      |=> status_q == $past(wd[BIT_CTRL_STATUS]))
      else $error("Host write did not reach the status bit.");

   pin_polarity_a: assert property (@(posedge clk_sys) disable iff (rst)
      shared_pin_twentyone_oe
      |-> shared_pin_twentyone_o == ($past(status_q) ^ $past(pol2_q[BIT_POL_WD])))
      else $error("Shared pin level ignores the polarity bit.");

   pin_release_a: assert property (@(posedge clk_sys) disable iff (rst)
      alt3_q[BIT_ALT3_LO+:2] != ALT3_WD_SEL
      |=> !shared_pin_twentyone_oe && !shared_pin_twentyone_o)
      else $error("Shared pin driven without the watchdog function.");

   event_status_a: assert property (@(posedge clk_sys) disable iff (rst)
      wd_event |=> pwr_sts_q && mgmt_sts_q)
      else $error("Event did not set the sticky status bits.");

   slot_map_a: assert property (@(posedge clk_sys) disable iff (rst)
      serirq_slot == $past(cfg_q[BIT_MAP_LO+:4]))
      else $error("Serial slot does not follow the mapping field.");

   force_read_a: assert property (@(posedge clk_sys) disable iff (rst)
      rd_q && addr_q == IDX_WD_CTRL |=> hrdata[BIT_CTRL_FORCE] == 1'b0)
      else $error("Force bit did not read back as zero.");

   second_step_a: assert property (@(posedge clk_sys) disable iff (rst)
      !unit_q[BIT_UNIT_MINUTES] && sec_tick && count_q != 8'h00 && !load && !force_wr
      |=> count_q == $past(count_q) - 8'h01)
      else $error("Counter did not step on a seconds tick.");

   minute_wrap_a: assert property (@(posedge clk_sys) disable iff (rst)
      min_tick |=> min_cnt_q == 6'h00 && sec_cnt_q == '0)
      else $error("Minute divider did not wrap.");

   read_wait_a: assert property (@(posedge clk_sys) disable iff (rst)
      hsel && htrans[1] && hready && !hwrite |=> read_wait_s)
      else $error("Read data phase did not take one wait state.");

   irq_level_a: assert property (@(posedge clk_sys) disable iff (rst)
      |(irq_sts_q & irq_en_q) |=> irq)
      else $error("Interrupt output low with an enabled status bit.");

endmodule

// *** bench/wdr_host_model.sv ***
`timescale 1ns/1ps
module wdr_host_model (
   // Clock and reset.
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Event lines from the device.
   input  wire logic       power_event_out_n,
   input  wire logic       mgmt_irq_out_n,
   input  wire logic [3:0] serirq_slot,
   // What the host has latched.
   output logic [7:0]      pwr_seen,
   output logic [7:0]      mgmt_seen,
   output logic [3:0]      slot_seen
);
   logic pwr_q;
   logic mgmt_q;
   // The host counts each assertion of the active-low event lines.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pwr_q     <= 1'b1;
         mgmt_q    <= 1'b1;
         pwr_seen  <= 8'h00;
         mgmt_seen <= 8'h00;
         slot_seen <= 4'h0;
      end else begin
         pwr_q  <= power_event_out_n;
         mgmt_q <= mgmt_irq_out_n;
         if (pwr_q && !power_event_out_n) begin
            pwr_seen  <= pwr_seen + 8'h01;
            slot_seen <= serirq_slot;
         end
         if (mgmt_q && !mgmt_irq_out_n) begin
            mgmt_seen <= mgmt_seen + 8'h01;
         end
      end
   end
endmodule

// *** bench/wdr_top_tb_top.sv ***
`timescale 1ns/1ps
module wdr_top_tb_top;
   import wdr_pkg::*;
   localparam int SEC = 10;
   logic        clk_sys;
   logic        rst;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   wire  logic  hready;
   logic [31:0] hrdata;
   logic        hresp;
   logic        pwr_n;
   logic        mgmt_n;
   logic        pin_o;
   logic        pin_oe;
   logic        sirq;
   logic [3:0]  slot;
   logic        irq;
   logic [7:0]  pwr_seen;
   logic [7:0]  mgmt_seen;
   logic [3:0]  slot_seen;
   logic [31:0] rd;
   int          err_count;
   int          total_checks;

   wdr_top #(.SEC_CYCLES(SEC)) i_dut (
      .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
      .power_event_out_n(pwr_n), .mgmt_irq_out_n(mgmt_n),
      .shared_pin_twentyone_o(pin_o), .shared_pin_twentyone_oe(pin_oe),
      .serirq_request(sirq), .serirq_slot(slot), .irq(irq));

   wdr_host_model i_host (
      .clk_sys(clk_sys), .rst(rst), .power_event_out_n(pwr_n),
      .mgmt_irq_out_n(mgmt_n), .serirq_slot(slot), .pwr_seen(pwr_seen),
      .mgmt_seen(mgmt_seen), .slot_seen(slot_seen));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic complete_run();
      if (err_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One single word transfer; read data are kept in rd.
   task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
      @(posedge clk_sys);
      hsel   <= 1'b1;
      haddr  <= {24'h0, idx, 2'b00};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge clk_sys);
      while (hready !== 1'b1) @(posedge clk_sys);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      @(posedge clk_sys);
      while (hready !== 1'b1) @(posedge clk_sys);
      rd = hrdata;
   endtask

   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask

   task automatic rdc(input string nm, input logic [5:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(nm, {24'h0, exp}, rd);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   initial begin
      repeat (6000) @(posedge clk_sys);
      err_count++;
      complete_run();
   end

   initial begin
      err_count = 0;
      total_checks = 0;
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      cyc(2);
      chk("pwr_n", 32'h1, pwr_n);
      chk("irq", 32'h0, irq);
      chk("hresp", 32'h0, hresp);
      chk("pin_oe idle", 32'h0, pin_oe);
      rdc("timeout_value", IDX_TIMEOUT_VAL, RST_TO_VAL);
      rdc("unmapped", 6'h3f, 8'h00);
      cyc(5 * SEC);
      rdc("ctrl idle", IDX_WD_CTRL, 8'h00);
      // Route the event to every destination, then arm three seconds.
      wr(IDX_PWR_EN, 8'h01);
      wr(IDX_PWR_EN2, 8'h80);
      wr(IDX_MGMT_EN3, 8'h01);
      wr(IDX_ALT_FUNC1, 8'h10);
      wr(IDX_ALT_FUNC3, 8'h08);
      wr(IDX_WD_CFG, 8'h50);
      wr(IDX_IRQ_EN, 8'h07);
      wr(IDX_TIMEOUT_VAL, 8'h03);
      cyc(SEC);
      rdc("ctrl early", IDX_WD_CTRL, 8'h00);
      cyc(3 * SEC);
      rdc("ctrl timeout", IDX_WD_CTRL, 8'h01);
      cyc(4);
      chk("pwr_n", 32'h0, pwr_n);
      chk("mgmt_n", 32'h0, mgmt_n);
      chk("pin_o", 32'h1, pin_o);
      chk("pin_oe", 32'h1, pin_oe);
      chk("serirq", 32'h1, sirq);
      chk("slot", 32'h5, slot_seen);
      chk("mgmt_seen", 32'h1, mgmt_seen);
      chk("irq", 32'h1, irq);
      rdc("pwr_sts2", IDX_PWR_STS2, 8'h80);
      rdc("mgmt_sts3", IDX_MGMT_STS3, 8'h01);
      rdc("irq_sts", IDX_IRQ_STS, 8'h03);
      wr(IDX_GPIO_POL2, 8'h02);
      cyc(3);
      chk("pin_o inv", 32'h0, pin_o);
      wr(IDX_GPIO_POL2, 8'h00);
      wr(IDX_IRQ_EN, 8'h00);
      cyc(2);
      chk("irq masked", 32'h0, irq);
      wr(IDX_IRQ_EN, 8'h07);
      wr(IDX_IRQ_CLR, 8'h07);
      wr(IDX_WD_CTRL, 8'h00);
      wr(IDX_PWR_STS2, 8'h80);
      wr(IDX_MGMT_STS3, 8'h01);
      cyc(3);
      chk("irq clr", 32'h0, irq);
      rdc("ctrl clr", IDX_WD_CTRL, 8'h00);
      chk("pwr_n clr", 32'h1, pwr_n);
      chk("pin_o clr", 32'h0, pin_o);
      chk("serirq clr", 32'h0, sirq);
      wr(IDX_WD_CTRL, 8'h01);
      cyc(4);
      chk("pwr_n set", 32'h0, pwr_n);
      wr(IDX_PWR_STS2, 8'h80);
      wr(IDX_WD_CTRL, 8'h01);
      cyc(4);
      rdc("pwr_sts2 no edge", IDX_PWR_STS2, 8'h00);
      chk("pwr_seen", 32'h2, pwr_seen);
      wr(IDX_WD_CTRL, 8'h00);
      wr(IDX_IRQ_CLR, 8'h07);
      wr(IDX_TIMEOUT_VAL, 8'hff);
      wr(IDX_WD_CTRL, 8'h04);
      cyc(2);
      rdc("ctrl force", IDX_WD_CTRL, 8'h01);
      rdc("irq_sts force", IDX_IRQ_STS, 8'h07);
      wr(IDX_WD_CTRL, 8'h00);
      cyc(30 * SEC);
      rdc("ctrl stopped", IDX_WD_CTRL, 8'h00);
      wr(IDX_TIMEOUT_VAL, 8'h05);
      wr(IDX_TIMEOUT_VAL, 8'h00);
      cyc(10 * SEC);
      rdc("ctrl off", IDX_WD_CTRL, 8'h00);
      wr(IDX_PWR_EN2, 8'h00);
      wr(IDX_PWR_STS2, 8'h80);
      wr(IDX_ALT_FUNC1, 8'h20);
      wr(IDX_ALT_FUNC3, 8'h04);
      wr(IDX_UNIT_SEL, 8'h80);
      rdc("unit_sel", IDX_UNIT_SEL, 8'h80);
      wr(IDX_TIMEOUT_VAL, 8'h02);
      cyc(50 * SEC);
      rdc("ctrl minutes", IDX_WD_CTRL, 8'h00);
      cyc(75 * SEC);
      rdc("ctrl min end", IDX_WD_CTRL, 8'h01);
      cyc(4);
      chk("pwr_n gated", 32'h1, pwr_n);
      chk("mgmt_n unsel", 32'h1, mgmt_n);
      chk("pin_oe unsel", 32'h0, pin_oe);
      chk("pwr_seen end", 32'h3, pwr_seen);
      chk("mgmt_seen end", 32'h2, mgmt_seen);
      rdc("pwr_sts2 gated", IDX_PWR_STS2, 8'h80);
      complete_run();
   end
endmodule
